// ### src/dsvl_status_velocity.sv
// Summary of operation
// - Status word bit layout as documented
// - Host control flag set on each valid state update, zero from reset
// - Sync bit follows fieldbus sync
// - Closed-loop ready needs setup and index
// - Low bits encode first four states
// - Low bits encode remaining four states
// - Target below minimum uses minimum, flags
// - Target above maximum uses maximum, flags
// - Min/max speed entries, writable, preset
// - Open-loop actual speed source selectable
// - Acceleration ramp pair with presets
// - Read-only signed speed demand
`timescale 1ns/1ps
`default_nettype none
module dsvl_status_velocity #(
  parameter int SPEED_W = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Object access port
  input  wire logic                objWrite,
  input  wire logic                objRead,
  input  wire logic [15:0]         objIndex,
  input  wire logic [7:0]          objSub,
  input  wire logic [31:0]         objWdata,
  output logic      [31:0]         objRdata,
  output logic                     objAck,
  output logic                     objError,
  // Power state machine and flags
  input  wire dsvl_pkg::dsvl_state_e driveState,
  input  wire logic                stateValid,
  input  wire logic                warning,
  input  wire logic                fieldbusSync,
  input  wire logic                goalReached,
  input  wire logic [1:0]          modeSpecificBits,
  input  wire logic                setupDone,
  input  wire logic                indexSeen,
  // Speed sources
  input  wire logic                openLoop,
  input  wire logic                actualFromEncoder,
  input  wire logic [SPEED_W-1:0]  calcSpeed,
  input  wire logic [SPEED_W-1:0]  encoderSpeed,
  input  wire logic [SPEED_W-1:0]  rampedSpeed,
  input  wire logic                rampedValid,
  // To the ramp generator, and the status word
  output logic      [SPEED_W-1:0]  limitedTarget,
  output logic      [31:0]         rampSpeedStep,
  output logic      [15:0]         rampTimeStep,
  output logic      [15:0]         statusWord
);
  // ==========================================================
  // Writable objects
  logic [SPEED_W-1:0] targetSpeed;
  logic [31:0]        minSpeed;
  logic [31:0]        maxSpeed;
  logic [SPEED_W-1:0] next_targetSpeed;
  logic [31:0]        next_minSpeed;
  logic [31:0]        next_maxSpeed;
  logic [31:0]        next_rampSpeedStep;
  logic [15:0]        next_rampTimeStep;

  always_comb begin
    next_targetSpeed   = targetSpeed;
    next_minSpeed      = minSpeed;
    next_maxSpeed      = maxSpeed;
    next_rampSpeedStep = rampSpeedStep;
    next_rampTimeStep  = rampTimeStep;
    if (objWrite) begin
      if (objIndex == dsvl_pkg::IDX_TARGET && objSub == dsvl_pkg::SUB_COUNT) begin
        next_targetSpeed = objWdata[SPEED_W-1:0];
      end
      if (objIndex == dsvl_pkg::IDX_MINMAX && objSub == dsvl_pkg::SUB_FIRST) begin
        next_minSpeed = objWdata;
      end
      if (objIndex == dsvl_pkg::IDX_MINMAX && objSub == dsvl_pkg::SUB_SECOND) begin
        next_maxSpeed = objWdata;
      end
      if (objIndex == dsvl_pkg::IDX_ACCEL && objSub == dsvl_pkg::SUB_FIRST) begin
        next_rampSpeedStep = objWdata;
      end
      if (objIndex == dsvl_pkg::IDX_ACCEL && objSub == dsvl_pkg::SUB_SECOND) begin
        next_rampTimeStep = objWdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      targetSpeed   <= SPEED_W'(dsvl_pkg::RST_TARGET);
      minSpeed      <= dsvl_pkg::RST_MIN_SPEED;
      maxSpeed      <= dsvl_pkg::RST_MAX_SPEED;
      rampSpeedStep <= dsvl_pkg::RST_RAMP_SPD;
      rampTimeStep  <= dsvl_pkg::RST_RAMP_TIME;
    end else begin
      targetSpeed   <= next_targetSpeed;
      minSpeed      <= next_minSpeed;
      maxSpeed      <= next_maxSpeed;
      rampSpeedStep <= next_rampSpeedStep;
      rampTimeStep  <= next_rampTimeStep;
    end
  end

  // ==========================================================
  // Speed limiting
  logic [SPEED_W-1:0] clampedSpeed;
  logic               limitNow;

  dsvl_speed_clamp #(
    .W (SPEED_W)
  ) u_clamp (
    .target   (targetSpeed),
    .minSpeed (minSpeed),
    .maxSpeed (maxSpeed),
    .clamped  (clampedSpeed),
    .limitHit (limitNow)
  );

  // ==========================================================
  // Speed demand, actual speed, limited target
  logic [SPEED_W-1:0] speedDemand;
  logic [SPEED_W-1:0] speedActual;
  logic [SPEED_W-1:0] next_speedDemand;
  logic [SPEED_W-1:0] next_speedActual;

  always_comb begin
    next_speedDemand = rampedValid ? rampedSpeed : speedDemand;
    next_speedActual = (openLoop && !actualFromEncoder) ? calcSpeed : encoderSpeed;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speedDemand   <= SPEED_W'(dsvl_pkg::RST_DEMAND);
      speedActual   <= SPEED_W'(dsvl_pkg::RST_ACTUAL);
      limitedTarget <= '0;
    end else begin
      speedDemand   <= next_speedDemand;
      speedActual   <= next_speedActual;
      limitedTarget <= clampedSpeed;
    end
  end

  // ==========================================================
  // Status word
  logic [15:0] next_statusWord;
  logic        readyToSwitchOn;
  logic        switchedOn;
  logic        operationEnabled;
  logic        faultFlag;
  logic        powerApplied;
  logic        quickStopN;
  logic        switchOnDisabled;

  always_comb begin
    unique case (driveState)
      dsvl_pkg::DSVL_NOT_READY: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b0;
        powerApplied     = 1'b0;
        faultFlag        = 1'b0;
        operationEnabled = 1'b0;
        switchedOn       = 1'b0;
        readyToSwitchOn  = 1'b0;
      end
      dsvl_pkg::DSVL_SW_ON_DISABLED: begin
        switchOnDisabled = 1'b1;
        quickStopN       = 1'b0;
        powerApplied     = 1'b0;
        faultFlag        = 1'b0;
        operationEnabled = 1'b0;
        switchedOn       = 1'b0;
        readyToSwitchOn  = 1'b0;
      end
      dsvl_pkg::DSVL_READY: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b1;
        powerApplied     = 1'b0;
        faultFlag        = 1'b0;
        operationEnabled = 1'b0;
        switchedOn       = 1'b0;
        readyToSwitchOn  = 1'b1;
      end
      dsvl_pkg::DSVL_SWITCHED_ON: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b1;
        powerApplied     = 1'b1;
        faultFlag        = 1'b0;
        operationEnabled = 1'b0;
        switchedOn       = 1'b1;
        readyToSwitchOn  = 1'b1;
      end
      dsvl_pkg::DSVL_OP_ENABLED: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b1;
        powerApplied     = 1'b1;
        faultFlag        = 1'b0;
        operationEnabled = 1'b1;
        switchedOn       = 1'b1;
        readyToSwitchOn  = 1'b1;
      end
      dsvl_pkg::DSVL_QUICK_STOP: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b0;
        powerApplied     = 1'b1;
        faultFlag        = 1'b0;
        operationEnabled = 1'b1;
        switchedOn       = 1'b1;
        readyToSwitchOn  = 1'b1;
      end
      dsvl_pkg::DSVL_FAULT_REACT: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b0;
        powerApplied     = 1'b0;
        faultFlag        = 1'b1;
        operationEnabled = 1'b1;
        switchedOn       = 1'b1;
        readyToSwitchOn  = 1'b1;
      end
      dsvl_pkg::DSVL_FAULT: begin
        switchOnDisabled = 1'b0;
        quickStopN       = 1'b0;
        powerApplied     = 1'b0;
        faultFlag        = 1'b1;
        operationEnabled = 1'b0;
        switchedOn       = 1'b0;
        readyToSwitchOn  = 1'b0;
      end
    endcase
    next_statusWord = statusWord;
    if (stateValid) begin
      next_statusWord = 16'h0000;
      next_statusWord[dsvl_pkg::BIT_SW_DIS]                       = switchOnDisabled;
      next_statusWord[dsvl_pkg::BIT_QSTOP]                        = quickStopN;
      next_statusWord[dsvl_pkg::BIT_PWR]                          = powerApplied;
      next_statusWord[dsvl_pkg::BIT_FAULT:dsvl_pkg::BIT_READY_SW] = {faultFlag, operationEnabled,
                                                                     switchedOn, readyToSwitchOn};
      next_statusWord[dsvl_pkg::BIT_WARN]                         = warning;
      next_statusWord[dsvl_pkg::BIT_SYNC]                         = fieldbusSync;
      next_statusWord[dsvl_pkg::BIT_HOST]                         = 1'b1;
      next_statusWord[dsvl_pkg::BIT_GOAL]                         = goalReached;
      next_statusWord[dsvl_pkg::BIT_LIMIT]                        = limitNow;
      next_statusWord[dsvl_pkg::BIT_MODE_HI:dsvl_pkg::BIT_MODE_LO] = modeSpecificBits;
      next_statusWord[dsvl_pkg::BIT_SPARE]                        = 1'b0;
      next_statusWord[dsvl_pkg::BIT_CLOSED]                       = setupDone & indexSeen;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      statusWord <= dsvl_pkg::RST_STATUS;
    end else begin
      statusWord <= next_statusWord;
    end
  end

  // ==========================================================
  // Object read / answer
  logic [31:0] next_objRdata;
  logic        next_objAck;
  logic        next_objError;
  logic        hit;
  logic        readOnly;

  always_comb begin
    hit           = 1'b1;
    readOnly      = 1'b0;
    next_objRdata = 32'h0000_0000;
    unique case ({objIndex, objSub})
      {dsvl_pkg::IDX_STATUS, dsvl_pkg::SUB_COUNT}: begin
        next_objRdata = {16'h0000, statusWord};
        readOnly      = 1'b1;
      end
      {dsvl_pkg::IDX_TARGET, dsvl_pkg::SUB_COUNT}: next_objRdata = 32'({{(32-SPEED_W){targetSpeed[SPEED_W-1]}}, targetSpeed});
      {dsvl_pkg::IDX_DEMAND, dsvl_pkg::SUB_COUNT}: begin
        next_objRdata = 32'({{(32-SPEED_W){speedDemand[SPEED_W-1]}}, speedDemand});
        readOnly      = 1'b1;
      end
      {dsvl_pkg::IDX_ACTUAL, dsvl_pkg::SUB_COUNT}: begin
        next_objRdata = 32'({{(32-SPEED_W){speedActual[SPEED_W-1]}}, speedActual});
        readOnly      = 1'b1;
      end
      {dsvl_pkg::IDX_MINMAX, dsvl_pkg::SUB_COUNT},
      {dsvl_pkg::IDX_ACCEL, dsvl_pkg::SUB_COUNT}: begin
        next_objRdata = {24'h000000, dsvl_pkg::SUB_NUM_TWO};
        readOnly      = 1'b1;
      end
      {dsvl_pkg::IDX_MINMAX, dsvl_pkg::SUB_FIRST}:  next_objRdata = minSpeed;
      {dsvl_pkg::IDX_MINMAX, dsvl_pkg::SUB_SECOND}: next_objRdata = maxSpeed;
      {dsvl_pkg::IDX_ACCEL, dsvl_pkg::SUB_FIRST}:   next_objRdata = rampSpeedStep;
      {dsvl_pkg::IDX_ACCEL, dsvl_pkg::SUB_SECOND}:  next_objRdata = {16'h0000, rampTimeStep};
      default: hit = 1'b0;
    endcase
    next_objAck   = objRead | objWrite;
    next_objError = (objRead | objWrite) & (~hit | (objWrite & readOnly));
    if (!objRead) begin
      next_objRdata = objRdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      objRdata <= 32'h0000_0000;
      objAck   <= 1'b0;
      objError <= 1'b0;
    end else begin
      objRdata <= next_objRdata;
      objAck   <= next_objAck;
      objError <= next_objError;
    end
  end
endmodule
`default_nettype wire

// ### include/dsvl_pkg.sv
`default_nettype none
package dsvl_pkg;
  // Object indices
  localparam logic [15:0] IDX_STATUS    = 16'h6041;
  localparam logic [15:0] IDX_TARGET    = 16'h6042;
  localparam logic [15:0] IDX_DEMAND    = 16'h6043;
  localparam logic [15:0] IDX_ACTUAL    = 16'h6044;
  localparam logic [15:0] IDX_MINMAX    = 16'h6046;
  localparam logic [15:0] IDX_ACCEL     = 16'h6048;
  // Subindices
  localparam logic [7:0]  SUB_COUNT     = 8'h00;
  localparam logic [7:0]  SUB_FIRST     = 8'h01;
  localparam logic [7:0]  SUB_SECOND    = 8'h02;
  localparam logic [7:0]  SUB_NUM_TWO   = 8'h02;
  // Status word bit positions
  localparam int BIT_READY_SW  = 0;
  localparam int BIT_SWON      = 1;
  localparam int BIT_OPEN      = 2;
  localparam int BIT_FAULT     = 3;
  localparam int BIT_PWR       = 4;
  localparam int BIT_QSTOP     = 5;
  localparam int BIT_SW_DIS    = 6;
  localparam int BIT_WARN      = 7;
  localparam int BIT_SYNC      = 8;
  localparam int BIT_HOST      = 9;
  localparam int BIT_GOAL      = 10;
  localparam int BIT_LIMIT     = 11;
  localparam int BIT_MODE_LO   = 12;
  localparam int BIT_MODE_HI   = 13;
  localparam int BIT_SPARE     = 14;
  localparam int BIT_CLOSED    = 15;
  // Reset values
  localparam logic [15:0] RST_STATUS    = 16'h0000;
  localparam logic [15:0] RST_TARGET    = 16'h0000;
  localparam logic [15:0] RST_DEMAND    = 16'h0000;
  localparam logic [15:0] RST_ACTUAL    = 16'h0000;
  localparam logic [31:0] RST_MIN_SPEED = 32'h0000_0000;
  localparam logic [31:0] RST_MAX_SPEED = 32'h0000_4e20;
  localparam logic [31:0] RST_RAMP_SPD  = 32'h0000_01f4;
  localparam logic [15:0] RST_RAMP_TIME = 16'h0001;
  // Low status patterns, bits 3:0 per state
  localparam logic [3:0]  LOW_NOT_READY = 4'h0;
  localparam logic [3:0]  LOW_READY     = 4'h1;
  localparam logic [3:0]  LOW_SWON      = 4'h3;
  localparam logic [3:0]  LOW_OPEN      = 4'h7;
  localparam logic [3:0]  LOW_REACT     = 4'hf;
  localparam logic [3:0]  LOW_FAULT     = 4'h8;

  typedef enum logic [2:0] {
    DSVL_NOT_READY,
    DSVL_SW_ON_DISABLED,
    DSVL_READY,
    DSVL_SWITCHED_ON,
    DSVL_OP_ENABLED,
    DSVL_QUICK_STOP,
    DSVL_FAULT_REACT,
    DSVL_FAULT
  } dsvl_state_e;
endpackage
`default_nettype wire

// ### src/dsvl_speed_clamp.sv
`timescale 1ns/1ps
`default_nettype none
module dsvl_speed_clamp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]  target,
  input  wire logic [31:0]   minSpeed,
  input  wire logic [31:0]   maxSpeed,
  output logic      [W-1:0]  clamped,
  output logic               limitHit
);
  logic        negative;
  logic [31:0] magnitude;
  logic [31:0] useMag;
  logic        belowMin;
  logic        aboveMax;

  always_comb begin
    negative  = target[W-1];
    magnitude = negative ? 32'(-signed'({{(32-W){target[W-1]}}, target})) : 32'({{(32-W){1'b0}}, target});
    belowMin  = magnitude < minSpeed;
    aboveMax  = magnitude > maxSpeed;
    useMag    = belowMin ? minSpeed : (aboveMax ? maxSpeed : magnitude);
    if (useMag > 32'(2**(W-1) - 1)) begin
      useMag = 32'(2**(W-1) - 1);
    end
    clamped   = negative ? W'(-useMag) : W'(useMag);
    limitHit  = belowMin | aboveMax;
  end
endmodule
`default_nettype wire

// ### tb/dsvl_status_velocity_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dsvl_status_velocity_checker (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  input  wire logic                  objWrite,
  input  wire logic                  objRead,
  input  wire logic                  objAck,
  input  wire logic                  objError,
  input  wire dsvl_pkg::dsvl_state_e driveState,
  input  wire logic                  stateValid,
  input  wire logic                  warning,
  input  wire logic                  fieldbusSync,
  input  wire logic                  setupDone,
  input  wire logic                  indexSeen,
  input  wire logic [31:0]           rampSpeedStep,
  input  wire logic [15:0]           rampTimeStep,
  input  wire logic [15:0]           statusWord
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================
  // Sequences
  sequence s_req; objRead || objWrite; endsequence
  sequence s_upd; stateValid; endsequence
  // ==========================
  // Properties
  property p_ack; s_req |=> objAck; endproperty
  property p_err; objError |-> objAck && $past(objRead || objWrite); endproperty
  property p_host; s_upd |=> statusWord[9]; endproperty
  property p_sync; s_upd |=> statusWord[8] == $past(fieldbusSync); endproperty
  property p_warn; s_upd |=> statusWord[7] == $past(warning); endproperty
  property p_closed; s_upd |=> statusWord[15] == $past(setupDone && indexSeen); endproperty
  property p_ready; s_upd ##0 driveState == dsvl_pkg::DSVL_READY |=> statusWord[6:5] == 2'h1 && statusWord[3:0] == 4'h1;
  endproperty
  property p_fault; s_upd ##0 driveState == dsvl_pkg::DSVL_FAULT |=> !statusWord[6] && statusWord[3:0] == 4'h8;
  endproperty
  property p_spare; !statusWord[14]; endproperty
  property p_rst; $fell(srst) |-> statusWord == 16'h0 && rampSpeedStep == 32'h1f4 && rampTimeStep == 16'h1;
  endproperty
  a_ack: assert property (p_ack) else $error("request without acknowledge");
  a_err: assert property (p_err) else $error("error flag without acknowledge");
  a_host: assert property (p_host) else $error("host control flag low");
  a_sync: assert property (p_sync) else $error("sync bit wrong");
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  a_closed: assert property (p_closed) else $error("closed loop bit wrong");
  a_ready: assert property (p_ready) else $error("ready pattern wrong");
  a_fault: assert property (p_fault) else $error("fault pattern wrong");
  a_spare: assert property (p_spare) else $error("bit 14 set");
  a_rst: assert property (p_rst) else $error("reset values wrong");
endmodule
bind dsvl_status_velocity dsvl_status_velocity_checker chk_u (.sys_clk(sys_clk), .srst(srst), .objWrite(objWrite),
  .objRead(objRead), .objAck(objAck), .objError(objError), .driveState(driveState), .stateValid(stateValid),
  .warning(warning), .fieldbusSync(fieldbusSync), .setupDone(setupDone), .indexSeen(indexSeen),
  .rampSpeedStep(rampSpeedStep), .rampTimeStep(rampTimeStep), .statusWord(statusWord));
`default_nettype wire

// ### tb/dsvl_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsvl_master_model (
  input  wire logic        sys_clk,
  input  wire logic        objAck,
  input  wire logic        objError,
  input  wire logic [31:0] objRdata,
  output logic             objWrite,
  output logic             objRead,
  output logic      [15:0] objIndex,
  output logic      [7:0]  objSub,
  output logic      [31:0] objWdata
);
  initial begin
    objWrite = 1'b0;
    objRead = 1'b0;
    objIndex = 16'h0;
    objSub = 8'h0;
    objWdata = 32'h0;
  end
  // ==========================
  // One object access
  // One pulse per access
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
    int n;
    @(posedge sys_clk);
    #1;
    objWrite = wr;
    objRead = !wr;
    {objIndex, objSub, objWdata} = {idx, sub, wd};
    @(posedge sys_clk);
    #1;
    objWrite = 1'b0;
    objRead = 1'b0;
    {objIndex, objSub, objWdata} = ~{idx, sub, wd};
    ok = (objAck === 1'b1);
    for (n = 0; n < 3 && !ok; n++) begin
      @(posedge sys_clk);
      #1;
      ok = (objAck === 1'b1);
    end
    rd = objRdata;
    err = objError;
  endtask
endmodule
`default_nettype wire

// ### tb/dsvl_status_velocity_test.sv
`timescale 1ns/1ps
`default_nettype none
module dsvl_status_velocity_test;
  logic clk = 1'b0, srst = 1'b1, stateValid = 1'b0, warning = 1'b0, fieldbusSync = 1'b0, goalReached = 1'b0;
  logic setupDone = 1'b0, indexSeen = 1'b0, openLoop = 1'b0, actualFromEncoder = 1'b0, rampedValid = 1'b0;
  logic [1:0] modeSpecificBits = 2'h0;
  logic [15:0] calcSpeed = 16'h0, encoderSpeed = 16'h0, rampedSpeed = 16'h0, objIndex, limitedTarget;
  logic [15:0] rampTimeStep, statusWord;
  logic [7:0] objSub;
  logic [31:0] objWdata, objRdata, rampSpeedStep;
  logic objWrite, objRead, objAck, objError;
  dsvl_pkg::dsvl_state_e driveState = dsvl_pkg::DSVL_NOT_READY;
  int n_errors = 0, n_compared = 0;
  always #4 clk = ~clk;
  dsvl_status_velocity dut_u (.sys_clk(clk), .srst(srst), .objWrite(objWrite), .objRead(objRead),
    .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata), .objRdata(objRdata), .objAck(objAck),
    .objError(objError), .driveState(driveState), .stateValid(stateValid), .warning(warning),
    .fieldbusSync(fieldbusSync), .goalReached(goalReached), .modeSpecificBits(modeSpecificBits),
    .setupDone(setupDone), .indexSeen(indexSeen), .openLoop(openLoop), .actualFromEncoder(actualFromEncoder),
    .calcSpeed(calcSpeed), .encoderSpeed(encoderSpeed), .rampedSpeed(rampedSpeed), .rampedValid(rampedValid),
    .limitedTarget(limitedTarget), .rampSpeedStep(rampSpeedStep), .rampTimeStep(rampTimeStep),
    .statusWord(statusWord));
  dsvl_master_model master_u (.sys_clk(clk), .objAck(objAck), .objError(objError), .objRdata(objRdata),
    .objWrite(objWrite), .objRead(objRead), .objIndex(objIndex), .objSub(objSub), .objWdata(objWdata));
  // ==========================
  // Shared helpers
  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      $display("[FAIL] %0t %s", $time, msg);
      n_errors++;
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                      input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err, ok;
    master_u.access(wr, idx, sub, wd, rd, err, ok);
    check(ok, "no acknowledge");
    if (!ok) begin
      give_verdict();
    end else begin
      check(err === experr, "error flag mismatch");
      check(wr || rd === exp, "read data mismatch");
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========================
  // Scenarios
  task automatic t_presets();
    xfer(0, dsvl_pkg::IDX_STATUS, 8'h00, 32'h0, 32'h0, 0);
    xfer(0, dsvl_pkg::IDX_MINMAX, 8'h02, 32'h0, 32'h4e20, 0);
    xfer(0, dsvl_pkg::IDX_MINMAX, 8'h00, 32'h0, 32'h2, 0);
    xfer(0, dsvl_pkg::IDX_ACCEL, 8'h01, 32'h0, 32'h1f4, 0);
    xfer(0, dsvl_pkg::IDX_ACCEL, 8'h02, 32'h0, 32'h1, 0);
    xfer(1, dsvl_pkg::IDX_ACCEL, 8'h01, 32'h0001_2345, 32'h0, 0);
    xfer(1, dsvl_pkg::IDX_ACCEL, 8'h02, 32'h0000_00c8, 32'h0, 0);
    check(rampSpeedStep === 32'h0001_2345 && rampTimeStep === 16'h00c8, "ramp outputs");
  endtask
  task automatic t_states();
    logic [5:0] ev[8] = '{6'h00, 6'h20, 6'h11, 6'h13, 6'h17, 6'h07, 6'h0f, 6'h08};
    logic [5:0] em[8] = '{6'h2f, 6'h2f, 6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h2f, 6'h2f};
    for (int i = 0; i < 8; i++) begin
      driveState = dsvl_pkg::dsvl_state_e'(i);
      {indexSeen, setupDone, fieldbusSync} = 3'(i);
      {warning, goalReached, modeSpecificBits} = 4'(i + 5);
      stateValid = 1'b1;
      settle();
      check((({statusWord[6:5], statusWord[3:0]} ^ ev[i]) & em[i]) === 6'h0, "state pattern");
      check(statusWord[4] === (i inside {3, 4, 5}), "power bit");
      check(statusWord[9] === 1'b1 && statusWord[14] === 1'b0, "fixed bits");
      check(statusWord[8] === fieldbusSync && statusWord[15] === (setupDone & indexSeen), "sync or loop");
      check({statusWord[13:12], statusWord[10], statusWord[7]} === {modeSpecificBits, goalReached, warning},
            "flag bits");
    end
  endtask
  task automatic t_clamp();
    logic [15:0] tv[4] = '{16'd50, 16'd2000, 16'd500, -16'sd2000};
    logic [15:0] lv[4] = '{16'd100, 16'd1000, 16'd500, -16'sd1000};
    xfer(1, dsvl_pkg::IDX_MINMAX, 8'h01, 32'd100, 32'h0, 0);
    xfer(1, dsvl_pkg::IDX_MINMAX, 8'h02, 32'd1000, 32'h0, 0);
    xfer(0, dsvl_pkg::IDX_MINMAX, 8'h01, 32'h0, 32'd100, 0);
    for (int i = 0; i < 4; i++) begin
      xfer(1, dsvl_pkg::IDX_TARGET, 8'h00, {16'h0, tv[i]}, 32'h0, 0);
      settle();
      check(limitedTarget === lv[i] && statusWord[11] === (i != 2), "clamp or limit flag");
    end
  endtask
  task automatic t_speeds();
    {openLoop, calcSpeed, encoderSpeed} = {1'b1, 16'h0123, 16'hff00};
    xfer(0, dsvl_pkg::IDX_ACTUAL, 8'h00, 32'h0, 32'h0000_0123, 0);
    actualFromEncoder = 1'b1;
    xfer(0, dsvl_pkg::IDX_ACTUAL, 8'h00, 32'h0, 32'hffff_ff00, 0);
    {openLoop, actualFromEncoder} = 2'b00;
    xfer(0, dsvl_pkg::IDX_ACTUAL, 8'h00, 32'h0, 32'hffff_ff00, 0);
    {rampedSpeed, rampedValid} = {16'h8001, 1'b1};
    @(posedge clk);
    #1;
    {rampedSpeed, rampedValid} = {16'h1111, 1'b0};
    xfer(1, dsvl_pkg::IDX_DEMAND, 8'h00, 32'h5, 32'h0, 1);
    xfer(0, dsvl_pkg::IDX_DEMAND, 8'h00, 32'h0, 32'hffff_8001, 0);
    xfer(1, dsvl_pkg::IDX_STATUS, 8'h00, 32'h5, 32'h0, 1);
    xfer(0, 16'h6045, 8'h00, 32'h0, 32'h0, 1);
  endtask
  task automatic t_reset();
    xfer(1, dsvl_pkg::IDX_MINMAX, 8'h02, 32'd3000, 32'h0, 0);
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    check(statusWord === dsvl_pkg::RST_STATUS && limitedTarget === 16'h0, "reset outputs");
    check(objAck === 1'b0 && objError === 1'b0, "reset answer");
    check(rampSpeedStep === dsvl_pkg::RST_RAMP_SPD && rampTimeStep === dsvl_pkg::RST_RAMP_TIME, "reset ramp");
    xfer(0, dsvl_pkg::IDX_MINMAX, 8'h02, 32'h0, dsvl_pkg::RST_MAX_SPEED, 0);
    settle();
    check(statusWord[9] === 1'b1 && statusWord[14] === 1'b0, "word after reset");
  endtask
  // ==========================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    t_presets();
    t_states();
    t_clamp();
    t_speeds();
    t_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
